// [clps_pkg.sv]
// What this block does
// - Loops run only from the oscillator clock
// - Loop behaviour set purely by digital values
// - Bandwidth, damping, lock range set directly
// - Loop arithmetic uses 54-bit resolution
// - Smoothing loop four decades wider than loop
// - Alarm register 11h: activity, lock, reset 22h
// - Holdover freezes output frequency immediately
// - Pick highest priority valid input, fall back
// - Frame-alignment failure never disqualifies input
`default_nettype none
package clps_pkg;
  // ************************************************
  // Register offsets
  // ************************************************
  localparam logic [7:0] CLPS_OFF_ID       = 8'h00;
  localparam logic [7:0] CLPS_OFF_REV      = 8'h01;
  localparam logic [7:0] CLPS_OFF_TEST1    = 8'h03;
  localparam logic [7:0] CLPS_OFF_TEST2    = 8'h04;
  localparam logic [7:0] CLPS_OFF_FLG_IN   = 8'h05;
  localparam logic [7:0] CLPS_OFF_FLG_MODE = 8'h06;
  localparam logic [7:0] CLPS_OFF_FRQ_TOP  = 8'h07;
  localparam logic [7:0] CLPS_OFF_FLG_SYNC = 8'h08;
  localparam logic [7:0] CLPS_OFF_STATE    = 8'h09;
  localparam logic [7:0] CLPS_OFF_RANK_LO  = 8'h0A;
  localparam logic [7:0] CLPS_OFF_RANK_HI  = 8'h0B;
  localparam logic [7:0] CLPS_OFF_FRQ_LO   = 8'h0C;
  localparam logic [7:0] CLPS_OFF_FRQ_MID  = 8'h0D;
  localparam logic [7:0] CLPS_OFF_VAL_LO   = 8'h0E;
  localparam logic [7:0] CLPS_OFF_VAL_HI   = 8'h0F;
  localparam logic [7:0] CLPS_OFF_ALM_SE   = 8'h11;
  localparam logic [7:0] CLPS_OFF_ALM_DF   = 8'h12;
  localparam logic [7:0] CLPS_OFF_ALM_SB   = 8'h14;
  localparam logic [7:0] CLPS_OFF_PRIO_SE  = 8'h19;
  localparam logic [7:0] CLPS_OFF_PRIO_DF  = 8'h1A;
  // ************************************************
  // Reset values
  // ************************************************
  localparam logic [7:0] CLPS_RST_TEST1    = 8'h14;
  localparam logic [7:0] CLPS_RST_TEST2    = 8'h12;
  localparam logic [7:0] CLPS_RST_FLG_IN   = 8'hFF;
  localparam logic [7:0] CLPS_RST_FLG_MODE = 8'h3F;
  localparam logic [7:0] CLPS_RST_FLG_SYNC = 8'h10;
  localparam logic [7:0] CLPS_RST_ALM      = 8'h22;
  localparam logic [7:0] CLPS_RST_PRIO_SE  = 8'h32;
  localparam logic [7:0] CLPS_RST_PRIO_DF  = 8'h00;
  // Identity values, arbitrary
  localparam logic [7:0] CLPS_ID_VAL       = 8'hA5;
  localparam logic [7:0] CLPS_REV_VAL      = 8'h07;
  // Fixed priority of the standby input
  localparam logic [3:0] CLPS_PRIO_STBY    = 4'h4;
  // ************************************************
  // Field positions and codes
  // ************************************************
  localparam int CLPS_NUM_IN     = 5;     // Inputs: pri SE, sec SE, pri DF, sec DF, standby
  localparam int CLPS_RES_W      = 54;    // Loop arithmetic width
  localparam int CLPS_FRQ_W      = 19;    // Reported frequency width
  localparam int CLPS_FRQ_LSB    = 35;    // Lowest reported accumulator bit
  localparam int CLPS_APLL_RATIO = 10000; // Smoothing loop bandwidth ratio
  localparam logic [2:0] CLPS_CODE_FREE = 3'h1;
  localparam logic [2:0] CLPS_CODE_HOLD = 3'h2;
  localparam logic [2:0] CLPS_CODE_LOCK = 3'h4;
  // ************************************************
  // Types
  // ************************************************
  typedef enum logic [1:0] {CLPS_FREE, CLPS_LOCK, CLPS_HOLD} clps_mode_t;
  typedef logic [CLPS_NUM_IN-1:0][3:0] clps_prio_t;
  typedef logic [2:0][3:0] clps_rank_t;
  // Input monitor results
  typedef struct packed {
    logic [4:0] valid;
    logic [4:0] noact;
    logic [4:0] phlock;
    logic [2:0] sync_alm;
  } clps_mon_t;
  // Loop settings
  typedef struct packed {
    logic [3:0]  bw_shift;
    logic [3:0]  damp_shift;
    logic [18:0] lock_range;
  } clps_loop_cfg_t;
endpackage
`default_nettype wire

// [clps_loop.sv]
`timescale 1ns/100ps
`default_nettype none
module clps_loop
  import clps_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Control
  input  wire clps_mode_t        mode,
  input  wire logic signed [15:0] phase_err,
  input  wire clps_loop_cfg_t    cfg,
  // Result
  output logic [CLPS_FRQ_W-1:0]  freq,
  output logic                   at_limit
);
  // ************************************************
  // State
  // ************************************************
  typedef struct packed {
    logic signed [CLPS_RES_W-1:0] integ; // Frequency integrator
    logic signed [CLPS_RES_W-1:0] outv;  // Loop output
    logic                         lim;   // Clamped at lock range
  } clps_loop_st_t;
  clps_loop_st_t st_r, st_nxt;
  logic signed [CLPS_RES_W-1:0] err_x;  // Extended error
  logic signed [CLPS_RES_W-1:0] sum;    // Integrator update
  logic signed [CLPS_RES_W-1:0] lim_hi; // Upper clamp
  logic [4:0]                   psh;    // Proportional shift

  // Loop update, every step a plain digital parameter
  always_comb
  begin
    st_nxt = st_r;
    err_x  = CLPS_RES_W'(phase_err);
    lim_hi = $signed({1'b0, cfg.lock_range, 34'h0});
    sum    = st_r.integ + (err_x <<< cfg.bw_shift);
    psh    = {1'b0, cfg.bw_shift} + {1'b0, cfg.damp_shift};
    unique case (mode)
      CLPS_FREE:
      begin
        st_nxt = '0;
      end
      CLPS_HOLD:
      begin
        st_nxt = st_r;
      end
      CLPS_LOCK:
      begin
        st_nxt.lim = 1'b1;
        if (sum > lim_hi)
          st_nxt.integ = lim_hi;
        else if (sum < -lim_hi)
          st_nxt.integ = -lim_hi;
        else
        begin
          st_nxt.integ = sum;
          st_nxt.lim   = 1'b0;
        end
        st_nxt.outv = st_nxt.integ + (err_x <<< psh);
      end
    endcase
  end

  // State register, driven only by the oscillator clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign freq     = st_r.outv[CLPS_FRQ_LSB +: CLPS_FRQ_W];
  assign at_limit = st_r.lim;

  // ************************************************
  // Checks
  // ************************************************
  property p_hold_freeze;
    @(posedge clk) disable iff (rst)
    (mode == CLPS_HOLD) |=> (freq == $past(freq));
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("holdover frequency moved");

  property p_freerun_zero;
    @(posedge clk) disable iff (rst)
    (mode == CLPS_FREE) |=> (freq == '0) && !at_limit;
  endproperty
  a_freerun_zero: assert property (p_freerun_zero) else $error("free run output not nominal");
endmodule
`default_nettype wire

// [clps_select.sv]
`timescale 1ns/100ps
`default_nettype none
module clps_select
  import clps_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Candidates
  input  wire logic [4:0] valid,
  input  wire clps_prio_t prio,
  // Ranking
  output clps_rank_t      rank,
  output logic [3:0]      sel
);
  // ************************************************
  // State
  // ************************************************
  typedef struct packed {
    clps_rank_t rank; // Three best valid inputs
    logic [3:0] sel;  // Selected input number
  } clps_sel_st_t;
  clps_sel_st_t st_r, st_nxt;
  logic [4:0] taken;  // Inputs already ranked
  logic [3:0] best_p; // Best priority so far
  logic [3:0] best_i; // Best input number so far

  // Ranking: lowest nonzero priority value wins, ties to lower index
  always_comb
  begin
    st_nxt = st_r;
    taken  = '0;
    best_p = '0;
    best_i = '0;
    for (int k = 0; k < 3; k++)
    begin
      best_p = 4'hF;
      best_i = 4'h0;
      for (int i = 0; i < CLPS_NUM_IN; i++)
      begin
        // Only activity validity counts, never frame alignment
        if (valid[i] && !taken[i] && prio[i] != 4'h0 && (best_i == 4'h0 || prio[i] < best_p))
        begin
          best_p = prio[i];
          best_i = 4'(i + 1);
        end
      end
      if (best_i != 4'h0)
        taken[3'(best_i - 4'h1)] = 1'b1;
      st_nxt.rank[k] = best_i;
    end
    st_nxt.sel = st_nxt.rank[0];
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign rank = st_r.rank;
  assign sel  = st_r.sel;

  // ************************************************
  // Checks
  // ************************************************
  property p_sel_none;
    @(posedge clk) disable iff (rst)
    (valid == '0) |=> (sel == 4'h0);
  endproperty
  a_sel_none: assert property (p_sel_none) else $error("input selected with none valid");

  property p_sel_valid;
    @(posedge clk) disable iff (rst)
    (st_nxt.sel != 4'h0) |-> valid[3'(st_nxt.sel - 4'h1)] && (prio[3'(st_nxt.sel - 4'h1)] != 4'h0);
  endproperty
  a_sel_valid: assert property (p_sel_valid) else $error("selected input was not valid");
endmodule
`default_nettype wire

// [clps_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module clps_regs
  import clps_pkg::*;
(
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  SYS_RST,
  // Register port
  input  wire logic [7:0]            REG_ADDR,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  input  wire logic [7:0]            REG_WDATA,
  output logic [7:0]                 REG_RDATA,
  // Input monitors
  input  wire clps_mon_t             IN_MON,
  input  wire logic signed [15:0]    PHASE_ERR,
  input  wire logic                  AUX_LOCKED,
  input  wire logic                  AUX_FREQ_ALARM,
  // Loop settings
  input  wire clps_loop_cfg_t        LOOP_CFG,
  // Loop results
  output logic [3:0]                 SEL_SOURCE,
  output logic [2:0]                 LOOP_STATE,
  output logic [CLPS_FRQ_W-1:0]      LOOP_FREQ
);
  // ************************************************
  // State
  // ************************************************
  typedef struct packed {
    clps_mode_t mode;      // Main loop state
    logic [7:0] test1;     // Factory test one
    logic [7:0] test2;     // Factory test two
    logic [7:0] flg_in;    // Input events
    logic [7:0] flg_mode;  // Mode and standby events
    logic [7:0] flg_sync;  // Frame alignment events
    logic [7:0] prio_se;   // Single ended priorities
    logic [7:0] prio_df;   // Differential priorities
    logic [7:0] alm_se;    // Single ended alarms
    logic [7:0] alm_df;    // Differential alarms
    logic [7:0] alm_sb;    // Standby alarms
    logic [4:0] prev_val;  // Validity last cycle
    logic       prev_sync; // Frame alarm last cycle
    logic [7:0] rdata;     // Read data
  } clps_main_st_t;
  clps_main_st_t st_r, st_nxt;

  // ************************************************
  // Submodule wiring
  // ************************************************
  clps_rank_t          rank;     // Ranked inputs
  logic [3:0]          sel;      // Selected input
  logic [CLPS_FRQ_W-1:0] freq;   // Loop frequency
  logic                at_limit; // Loop at lock range
  clps_prio_t          prio;     // Priority table
  logic [7:0]          rd_mux;   // Read selection
  logic [2:0]          code;     // Reported loop state
  logic [4:0]          val_chg;  // Validity edges
  logic                sync_any; // Any frame alarm
  logic                lost;     // Selected input failed
  logic                mode_chg; // Loop state changed
  logic [7:0]          clr;      // Clear mask

  // Priority table, standby entry fixed
  assign prio = {CLPS_PRIO_STBY, st_r.prio_df[7:4], st_r.prio_df[3:0],
                 st_r.prio_se[7:4], st_r.prio_se[3:0]};

  // Input selection
  clps_select u_select (
    .clk   (CLK),
    .rst   (SYS_RST),
    .valid (IN_MON.valid),
    .prio  (prio),
    .rank  (rank),
    .sel   (sel)
  );

  // Digital loop
  clps_loop u_loop (
    .clk       (CLK),
    .rst       (SYS_RST),
    .mode      (st_r.mode),
    .phase_err (PHASE_ERR),
    .cfg       (LOOP_CFG),
    .freq      (freq),
    .at_limit  (at_limit)
  );

  // ************************************************
  // Loop state code
  // ************************************************
  always_comb
  begin
    unique case (st_r.mode)
      CLPS_FREE: code = CLPS_CODE_FREE;
      CLPS_LOCK: code = CLPS_CODE_LOCK;
      CLPS_HOLD: code = CLPS_CODE_HOLD;
      default:   code = CLPS_CODE_FREE;  // Unused encoding
    endcase
  end

  // ************************************************
  // Read selection
  // ************************************************
  always_comb
  begin
    unique case (REG_ADDR)
      CLPS_OFF_ID:       rd_mux = CLPS_ID_VAL;
      CLPS_OFF_REV:      rd_mux = CLPS_REV_VAL;
      CLPS_OFF_TEST1:    rd_mux = st_r.test1;
      CLPS_OFF_TEST2:    rd_mux = st_r.test2;
      CLPS_OFF_FLG_IN:   rd_mux = st_r.flg_in;
      CLPS_OFF_FLG_MODE: rd_mux = st_r.flg_mode;
      CLPS_OFF_FRQ_TOP:  rd_mux = {5'h00, freq[18:16]};
      CLPS_OFF_FLG_SYNC: rd_mux = st_r.flg_sync;
      CLPS_OFF_STATE:    rd_mux = {sync_any, AUX_LOCKED, at_limit, AUX_FREQ_ALARM, 1'b0, code};
      CLPS_OFF_RANK_LO:  rd_mux = {rank[0], sel};
      CLPS_OFF_RANK_HI:  rd_mux = {rank[2], rank[1]};
      CLPS_OFF_FRQ_LO:   rd_mux = freq[7:0];
      CLPS_OFF_FRQ_MID:  rd_mux = freq[15:8];
      CLPS_OFF_VAL_LO:   rd_mux = {2'b00, IN_MON.valid[3:0], 2'b00};
      CLPS_OFF_VAL_HI:   rd_mux = {7'h00, IN_MON.valid[4]};
      CLPS_OFF_ALM_SE:   rd_mux = st_r.alm_se;
      CLPS_OFF_ALM_DF:   rd_mux = st_r.alm_df;
      CLPS_OFF_ALM_SB:   rd_mux = st_r.alm_sb;
      CLPS_OFF_PRIO_SE:  rd_mux = st_r.prio_se;
      CLPS_OFF_PRIO_DF:  rd_mux = st_r.prio_df;
      default:           rd_mux = 8'h00;   // Unmapped reads zero
    endcase
  end

  // ************************************************
  // Event detection
  // ************************************************
  assign sync_any = |IN_MON.sync_alm;
  assign val_chg  = IN_MON.valid ^ st_r.prev_val;
  // Selected input dropped while locked
  assign lost     = (st_r.mode == CLPS_LOCK) && (sel != 4'h0) && !IN_MON.valid[3'(sel - 4'h1)];

  // ************************************************
  // Next state
  // ************************************************
  always_comb
  begin
    st_nxt    = st_r;
    // Loop state sequence
    unique case (st_r.mode)
      CLPS_FREE:
      begin
        if (sel != 4'h0)
          st_nxt.mode = CLPS_LOCK;
      end
      CLPS_LOCK:
      begin
        if (sel == 4'h0)
          st_nxt.mode = CLPS_HOLD;
      end
      CLPS_HOLD:
      begin
        if (sel != 4'h0)
          st_nxt.mode = CLPS_LOCK;
      end
    endcase
    mode_chg = (st_nxt.mode != st_r.mode);
    // Alarm snapshots
    st_nxt.alm_se = {2'b00, IN_MON.noact[1], IN_MON.phlock[1], 2'b00,
                     IN_MON.noact[0], IN_MON.phlock[0]};
    st_nxt.alm_df = {2'b00, IN_MON.noact[3], IN_MON.phlock[3], 2'b00,
                     IN_MON.noact[2], IN_MON.phlock[2]};
    st_nxt.alm_sb = {6'h00, IN_MON.noact[4], IN_MON.phlock[4]};
    st_nxt.prev_val  = IN_MON.valid;
    st_nxt.prev_sync = sync_any;
    // Plain writes
    if (REG_WR)
    begin
      unique case (REG_ADDR)
        CLPS_OFF_TEST1:   st_nxt.test1   = REG_WDATA;
        CLPS_OFF_TEST2:   st_nxt.test2   = REG_WDATA;
        CLPS_OFF_PRIO_SE: st_nxt.prio_se = REG_WDATA;
        CLPS_OFF_PRIO_DF: st_nxt.prio_df = REG_WDATA;
        default:          st_nxt.test1   = st_r.test1;
      endcase
    end
    // Event flags: write one clears, a new event wins
    clr = REG_WR ? REG_WDATA : 8'h00;
    st_nxt.flg_in   = (st_r.flg_in & ~((REG_ADDR == CLPS_OFF_FLG_IN) ? clr : 8'h00))
                    | {2'b00, val_chg[3:0], 2'b00};
    st_nxt.flg_mode = (st_r.flg_mode & ~((REG_ADDR == CLPS_OFF_FLG_MODE) ? clr : 8'h00))
                    | {mode_chg, lost, 5'h00, val_chg[4]};
    st_nxt.flg_sync = (st_r.flg_sync & ~((REG_ADDR == CLPS_OFF_FLG_SYNC) ? clr : 8'h00))
                    | {sync_any && !st_r.prev_sync, 7'h00};
    // Read data
    if (REG_RD)
      st_nxt.rdata = rd_mux;
  end

  // ************************************************
  // State register
  // ************************************************
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_r           <= '0;
      st_r.mode      <= CLPS_FREE;
      st_r.test1     <= CLPS_RST_TEST1;
      st_r.test2     <= CLPS_RST_TEST2;
      st_r.flg_in    <= CLPS_RST_FLG_IN;
      st_r.flg_mode  <= CLPS_RST_FLG_MODE;
      st_r.flg_sync  <= CLPS_RST_FLG_SYNC;
      st_r.prio_se   <= CLPS_RST_PRIO_SE;
      st_r.prio_df   <= CLPS_RST_PRIO_DF;
      st_r.alm_se    <= CLPS_RST_ALM;
      st_r.alm_df    <= CLPS_RST_ALM;
      st_r.alm_sb    <= CLPS_RST_ALM;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs
  assign REG_RDATA  = st_r.rdata;
  assign SEL_SOURCE = sel;
  assign LOOP_STATE = code;
  assign LOOP_FREQ  = freq;

  // ************************************************
  // Checks
  // ************************************************
  property p_alarm_map;
    @(posedge CLK) disable iff (SYS_RST)
    1'b1 |=> (st_r.alm_se == {2'b00, $past(IN_MON.noact[1]), $past(IN_MON.phlock[1]), 2'b00,
                              $past(IN_MON.noact[0]), $past(IN_MON.phlock[0])});
  endproperty
  a_alarm_map: assert property (p_alarm_map) else $error("alarm register mismatch");

  property p_freq_read;
    @(posedge CLK) disable iff (SYS_RST)
    (REG_RD && REG_ADDR == CLPS_OFF_FRQ_LO) |=> (REG_RDATA == $past(freq[7:0]));
  endproperty
  a_freq_read: assert property (p_freq_read) else $error("frequency low byte wrong");

  property p_hold_entry;
    @(posedge CLK) disable iff (SYS_RST)
    (st_r.mode == CLPS_LOCK && sel == 4'h0) |=> (st_r.mode == CLPS_HOLD) ##1 (LOOP_FREQ == $past(LOOP_FREQ));
  endproperty
  a_hold_entry: assert property (p_hold_entry) else $error("holdover not entered at once");

  property p_sync_keep;
    @(posedge CLK) disable iff (SYS_RST)
    (sync_any && $stable(IN_MON.valid) && $stable(prio)) |=> $stable(sel);
  endproperty
  a_sync_keep: assert property (p_sync_keep) else $error("frame alarm changed selection");

  property p_prio_write;
    @(posedge CLK) disable iff (SYS_RST)
    (REG_WR && REG_ADDR == CLPS_OFF_PRIO_SE) |=> (st_r.prio_se == $past(REG_WDATA));
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("priority write lost");

  property p_prio_df_write;
    @(posedge CLK) disable iff (SYS_RST)
    (REG_WR && REG_ADDR == CLPS_OFF_PRIO_DF) |=> (st_r.prio_df == $past(REG_WDATA));
  endproperty
  a_prio_df_write: assert property (p_prio_df_write) else $error("differential priority write lost");

  property p_lock_entry;
    @(posedge CLK) disable iff (SYS_RST)
    (st_r.mode != CLPS_LOCK && sel != 4'h0) |=> (st_r.mode == CLPS_LOCK);
  endproperty
  a_lock_entry: assert property (p_lock_entry) else $error("valid source not taken");

  property p_loss_flag;
    @(posedge CLK) disable iff (SYS_RST)
    (st_r.mode == CLPS_LOCK && sel == 4'h0) |=> st_r.flg_mode[7];
  endproperty
  a_loss_flag: assert property (p_loss_flag) else $error("state change not flagged");

  property p_rank_read;
    @(posedge CLK) disable iff (SYS_RST)
    (REG_RD && REG_ADDR == CLPS_OFF_RANK_LO) |=> (REG_RDATA[7:4] == REG_RDATA[3:0]) && (REG_RDATA[3:0] == $past(sel));
  endproperty
  a_rank_read: assert property (p_rank_read) else $error("ranking report wrong");

  property p_valid_read;
    @(posedge CLK) disable iff (SYS_RST)
    (REG_RD && REG_ADDR == CLPS_OFF_VAL_LO) |=> (REG_RDATA[5:2] == $past(IN_MON.valid[3:0]));
  endproperty
  a_valid_read: assert property (p_valid_read) else $error("validity report wrong");

  property p_freq_top_read;
    @(posedge CLK) disable iff (SYS_RST)
    (REG_RD && REG_ADDR == CLPS_OFF_FRQ_TOP) |=> (REG_RDATA == {5'h00, $past(freq[18:16])});
  endproperty
  a_freq_top_read: assert property (p_freq_top_read) else $error("frequency top bits wrong");

  property p_freq_mid_read;
    @(posedge CLK) disable iff (SYS_RST)
    (REG_RD && REG_ADDR == CLPS_OFF_FRQ_MID) |=> (REG_RDATA == $past(freq[15:8]));
  endproperty
  a_freq_mid_read: assert property (p_freq_mid_read) else $error("frequency middle byte wrong");
endmodule
`default_nettype wire

// [clps_regs_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module clps_regs_bench
  import clps_pkg::*;
;
  // ********************
  // Signals
  // ********************
  logic               clk;
  logic               sys_rst;
  logic               reg_wr;
  logic               reg_rd;
  logic [7:0]         reg_addr;
  logic [7:0]         reg_wdata;
  logic [7:0]         reg_rdata;
  clps_mon_t          in_mon;
  clps_mon_t          m;          // Monitor value of this round
  logic signed [15:0] phase_err;
  logic               aux_locked;
  logic               aux_alarm;
  clps_loop_cfg_t     loop_cfg;
  logic [3:0]         sel_source;
  logic [2:0]         loop_state;
  logic [18:0]        loop_freq;
  logic [18:0]        f;          // Frozen frequency
  logic [15:0]        fr;         // Low frequency bytes
  logic [7:0]         d;
  logic [7:0]         p19;
  logic [7:0]         p1a;
  int                 fail_count;
  int                 n_checks;
  // Reset table: offset, value
  localparam logic [15:0] RST_TAB [22] = '{{CLPS_OFF_ID, CLPS_ID_VAL}, {CLPS_OFF_REV, CLPS_REV_VAL},
    16'h0200, 16'h0314, 16'h0412, 16'h05FF, 16'h063F, 16'h0700, 16'h0810, 16'h0901, 16'h0A00,
    16'h0B00, 16'h0C00, 16'h0D00, 16'h0E00, 16'h0F00, 16'h1122, 16'h1222, 16'h1402, 16'h1932,
    16'h1A00, 16'h1F00};
  // Access table: writable flag, offset, value kept
  localparam logic [16:0] ACC_TAB [5] = '{17'h10300, 17'h10400, {1'b0, CLPS_OFF_ID, CLPS_ID_VAL},
    17'h00E00, 17'h00200};

  clps_regs i_clps_regs (.CLK(clk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .IN_MON(in_mon),
    .PHASE_ERR(phase_err), .AUX_LOCKED(aux_locked), .AUX_FREQ_ALARM(aux_alarm),
    .LOOP_CFG(loop_cfg), .SEL_SOURCE(sel_source), .LOOP_STATE(loop_state), .LOOP_FREQ(loop_freq));

  // ********************
  // Clock, compares, bus
  // ********************
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [18:0] got, input logic [18:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One write strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // One read strobe, data one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Data stands until the next read strobe
    @(posedge clk);
    v = reg_rdata;
  endtask

  // Best valid input: lowest nonzero priority, lower index on tie
  function automatic logic [3:0] exp_sel(input logic [4:0] v, input logic [7:0] a, input logic [7:0] b);
    logic [3:0] p [5];
    logic [3:0] best;
    p = '{a[3:0], a[7:4], b[3:0], b[7:4], CLPS_PRIO_STBY};
    best = 4'h0;
    for (int i = 0; i < 5; i++)
      if (v[i] && p[i] != 4'h0 && (best == 4'h0 || p[i] < p[best-1]))
        best = 4'(i + 1);
    return best;
  endfunction

  // Alarm byte for a pair of inputs
  function automatic logic [7:0] exp_alm(input logic [1:0] na, input logic [1:0] pl);
    return {2'h0, na[1], pl[1], 2'h0, na[0], pl[0]};
  endfunction

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, phase_err, aux_locked, aux_alarm} = '0;
    in_mon = '0;
    in_mon.noact = 5'h1F;
    loop_cfg = {4'hF, 4'hF, 19'h7FFFF};
    fail_count = 0;
    n_checks = 0;
    void'($urandom(32'hF06A53B0));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    #1 chk_val(19'(loop_state), 19'(CLPS_CODE_FREE));
    chk_val(loop_freq, 19'h00000);
    foreach (RST_TAB[i])
    begin
      rd(RST_TAB[i][15:8], d);
      chk_reg(d, RST_TAB[i][7:0]);
    end
    // Writable, read-only and unmapped places
    foreach (ACC_TAB[i])
    begin
      p19 = 8'($urandom);
      wr(ACC_TAB[i][15:8], p19);
      rd(ACC_TAB[i][15:8], d);
      chk_reg(d, ACC_TAB[i][16] ? p19 : ACC_TAB[i][7:0]);
    end
    // Flags: clear, then a validity event
    wr(8'h05, 8'hFF);
    rd(8'h05, d);
    chk_reg(d & 8'h3C, 8'h00);
    in_mon.valid <= 5'h01;
    repeat (4) @(posedge clk);
    rd(8'h05, d);
    chk_reg(d & 8'h3C, 8'h04);
    rd(8'h06, d);
    chk_reg(d & 8'h80, 8'h80);
    in_mon.sync_alm <= 3'h1;
    repeat (3) @(posedge clk);
    rd(8'h08, d);
    chk_reg(d & 8'h80, 8'h80);
    chk_val(19'(sel_source), 19'h00001);
    // Random selection rounds, corners first
    for (int n = 0; n < 30; n++)
    begin
      {p19, p1a} = (n == 0) ? 16'h0000 : (n == 1) ? 16'h2222 : (n == 2) ? 16'hFFFF : 16'($urandom);
      m = 18'($urandom);
      if (n < 3)
        m.valid = 5'h1F;
      wr(8'h19, p19);
      wr(8'h1A, p1a);
      in_mon <= m;
      aux_locked <= 1'($urandom);
      aux_alarm <= 1'($urandom);
      repeat (3) @(posedge clk);
      #1 chk_val(19'(sel_source), 19'(exp_sel(m.valid, p19, p1a)));
      rd(8'h0A, d);
      chk_reg(d, {2{exp_sel(m.valid, p19, p1a)}});
      rd(8'h0E, d);
      chk_reg(d, {2'h0, m.valid[3:0], 2'h0});
      rd(8'h0F, d);
      chk_reg(d, {7'h00, m.valid[4]});
      rd(8'h11, d);
      chk_reg(d, exp_alm(m.noact[1:0], m.phlock[1:0]));
      rd(8'h12, d);
      chk_reg(d, exp_alm(m.noact[3:2], m.phlock[3:2]));
      rd(8'h14, d);
      chk_reg(d, {6'h00, m.noact[4], m.phlock[4]});
      rd(8'h09, d);
      chk_reg(d & 8'hD0, {|m.sync_alm, aux_locked, 1'b0, aux_alarm, 4'h0});
      rd(8'h19, d);
      chk_reg(d, p19);
    end
    // Lock on standby, then holdover freeze
    in_mon <= {5'h10, 13'h0000}; // Standby valid only
    phase_err <= 16'sh4000;
    repeat (20) @(posedge clk);
    #1 chk_val(19'(loop_state), 19'(CLPS_CODE_LOCK));
    @(posedge clk);
    in_mon.valid <= 5'h00;
    repeat (4) @(posedge clk);
    #1 f = loop_freq;
    chk_val(19'(loop_state), 19'(CLPS_CODE_HOLD));
    chk_val(19'(f !== 19'h00000), 19'h00001);
    @(posedge clk);
    phase_err <= -16'sh1234;
    repeat (10) @(posedge clk);
    #1 chk_val(loop_freq, f);
    rd(8'h0C, fr[7:0]);
    rd(8'h0D, fr[15:8]);
    rd(8'h07, d);
    chk_val({d[2:0], fr}, f);
    rd(8'h09, d);
    chk_reg(d & 8'h07, {5'h00, CLPS_CODE_HOLD});
    in_mon.valid <= 5'h10;
    repeat (4) @(posedge clk);
    #1 chk_val(19'(loop_state), 19'(CLPS_CODE_LOCK));
    // Narrow lock range: integrator clamps at 1<<34, output adds 4000h<<30
    @(posedge clk);
    loop_cfg <= {4'hF, 4'hF, 19'h00001};
    phase_err <= 16'sh4000;
    repeat (30) @(posedge clk);
    #1 chk_val(loop_freq, 19'h00200);
    rd(8'h09, d);
    chk_reg(d & 8'h27, {2'b00, 1'b1, 2'b00, CLPS_CODE_LOCK});
    give_verdict();
  end
endmodule
`default_nettype wire
